/* pkg/uart_status_map.vh */
// Overview of operation
// - status bit 1 shows receive byte waiting
// - receive full raises interrupt 5 when enabled
// - data register read clears receive full
// - status bit 0 shows transmit busy
// - transmit empty raises interrupt 4 when enabled
// - one enable bit gates both interrupts
// - data write sets transmit full
// - transmit full clears after stop bit
// - data write starts serial transmission
// - data byte lives in low eight bits
// - status ignores writes, resets to zero
// - three-bit field picks eight baud rates
// - prescale bit divides baud by eight
// - enable off releases transmit pin
`ifndef UART_STATUS_MAP_VH
`define UART_STATUS_MAP_VH

// ========================================
// register addresses
`define UART_IEN_ADDR        16'hc00e
`define UART_CTRL_ADDR       16'hc0e0
`define UART_STAT_ADDR       16'hc0e2
`define UART_DATA_ADDR       16'hc0e4
`define UART_EVT_ADDR        16'hc0e6
`define UART_EMASK_ADDR      16'hc0e8

// ========================================
// field positions
`define CTRL_EN_BIT          0
`define CTRL_BAUD_LSB        1
`define CTRL_BAUD_MSB        3
`define CTRL_SCALE_BIT       4
`define STAT_TXF_BIT         0
`define STAT_RXF_BIT         1
`define IEN_UART_BIT         4
`define EVT_TXDONE_BIT       0
`define EVT_RXDONE_BIT       1
`define EVT_OVERRUN_BIT      2
`define DATA_MSB             7

// ========================================
// reset values
`define CTRL_EN_RST          1'b1
`define CTRL_BAUD_RST        3'h3
`define CTRL_SCALE_RST       1'b0
`define IEN_UART_RST         1'b0
`define EVT_RST              3'h0
`define EMASK_RST            3'h0
`define STAT_RST             16'h0000

// ========================================
// timing
`define CORE_CLK_HZ          40000000
`define CORE_CLK_PERIOD_NS   25
`define PRESCALE_DIV         8
`define BAUD_RATE_0          115200
`define BAUD_RATE_1          57600
`define BAUD_RATE_2          38400
`define BAUD_RATE_3          28800
`define BAUD_RATE_4          19200
`define BAUD_RATE_5          14400
`define BAUD_RATE_6          9600
`define BAUD_RATE_7          7200

`endif

/* rtl/uart_rx_deframer.v */
`timescale 1ns/100ps
`include "uart_status_map.vh"

module uart_rx_deframer (
    input  wire        i_core_clk,    // core clock
    input  wire        i_reset,       // sync reset, high
    input  wire        i_enable,      // uart enabled
    input  wire [15:0] i_period,      // cycles per bit
    input  wire        i_rxd,         // serial input
    output reg  [7:0]  o_byte,        // last received byte
    output reg         o_valid        // one-cycle pulse per byte
);

    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_START = 2'd1;
    localparam [1:0] ST_DATA  = 2'd2;
    localparam [1:0] ST_STOP  = 2'd3;

    reg [1:0]  state_q;
    reg [15:0] cnt_q;
    reg [2:0]  bit_q;
    reg [7:0]  shift_q;

    // ========================================
    // frame capture, sampling mid-bit
    always @(posedge i_core_clk) begin
        if (i_reset || !i_enable) begin
            state_q <= ST_IDLE;
            cnt_q   <= 16'h0000;
            bit_q   <= 3'h0;
            shift_q <= 8'h00;
            o_valid <= 1'b0;
            if (i_reset) begin
                o_byte <= 8'h00;
            end
        end else begin
            o_valid <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (!i_rxd) begin
                        state_q <= ST_START;
                        cnt_q   <= {1'b0, i_period[15:1]};
                    end
                end
                ST_START: begin
                    if (cnt_q == 16'h0000) begin
                        // glitch shorter than half a bit is dropped
                        state_q <= i_rxd ? ST_IDLE : ST_DATA;
                        cnt_q   <= i_period - 16'h0001;
                        bit_q   <= 3'h0;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_DATA: begin
                    if (cnt_q == 16'h0000) begin
                        shift_q <= {i_rxd, shift_q[7:1]};
                        cnt_q   <= i_period - 16'h0001;
                        if (bit_q == 3'h7) begin
                            state_q <= ST_STOP;
                        end
                        bit_q <= bit_q + 3'h1;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_STOP: begin
                    if (cnt_q == 16'h0000) begin
                        state_q <= ST_IDLE;
                        // bad stop bit discards the byte
                        if (i_rxd) begin
                            o_byte  <= shift_q;
                            o_valid <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // uart_rx_deframer

/* rtl/uart_status_and_data_path.v */
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "uart_status_map.vh"

module uart_status_and_data_path #(
    parameter integer CLK_HZ = `CORE_CLK_HZ  // shorten for simulation
) (
    input  wire        i_core_clk,      // core clock, 40 MHz
    input  wire        i_reset,         // sync reset, high
    input  wire [15:0] i_addr,          // register address
    input  wire [15:0] i_wr_data,       // write data
    input  wire        i_wr_stb,        // write strobe
    input  wire        i_rd_stb,        // read strobe
    output reg  [15:0] o_rd_data,       // read data, cycle after strobe
    input  wire        i_rxd,           // serial receive line
    output reg         o_txd,           // serial transmit line
    output reg         o_txd_oe,        // transmit pin driven
    output reg         o_int_rx_full,   // interrupt 5 request
    output reg         o_int_tx_empty,  // interrupt 4 request
    output reg         o_irq            // masked event interrupt
);

    localparam [1:0] TX_IDLE  = 2'd0;
    localparam [1:0] TX_START = 2'd1;
    localparam [1:0] TX_DATA  = 2'd2;
    localparam [1:0] TX_STOP  = 2'd3;

    // ========================================
    // bit period from baud code and prescale
    function [15:0] bit_cycles;
        input [2:0] sel;
        input       scale;
        integer     baud;
        integer     cyc;
        begin
            baud = `BAUD_RATE_0;
            case (sel)
                3'h0: baud = `BAUD_RATE_0;
                3'h1: baud = `BAUD_RATE_1;
                3'h2: baud = `BAUD_RATE_2;
                3'h3: baud = `BAUD_RATE_3;
                3'h4: baud = `BAUD_RATE_4;
                3'h5: baud = `BAUD_RATE_5;
                3'h6: baud = `BAUD_RATE_6;
                3'h7: baud = `BAUD_RATE_7;
                default: baud = `BAUD_RATE_0;
            endcase
            if (scale) begin
                baud = baud / `PRESCALE_DIV;
            end
            cyc = CLK_HZ / baud;
            if (cyc < 2) begin
                cyc = 2;
            end
            bit_cycles = cyc[15:0];
        end
    endfunction

    // ========================================
    // software-visible state
    reg        uart_en_q;
    reg [2:0]  baud_sel_q;
    reg        prescale_active_q;
    reg        uart_ien_q;
    reg        rx_full_q;
    reg [7:0]  rx_byte_q;
    reg        tx_full_q;
    reg [2:0]  evt_q;
    reg [2:0]  emask_q;

    // ========================================
    // transmit engine state
    reg [1:0]  tx_state_q;
    reg [15:0] tx_cnt_q;
    reg [2:0]  tx_bit_q;
    reg [7:0]  tx_shift_q;

    wire [15:0] period;
    wire [7:0]  rx_new_byte;
    wire        rx_new_valid;
    wire        wr_ctrl;
    wire        wr_data;
    wire        wr_ien;
    wire        wr_emask;
    wire        rd_data;
    wire        rd_evt;
    wire        tx_done;
    wire        tx_accept;

    reg  [15:0] rd_data_d;
    reg  [2:0]  evt_d;

    // baud change mid-frame takes effect at the next bit boundary
    assign period = bit_cycles(baud_sel_q, prescale_active_q);

    // status register has no write decode at all
    assign wr_ctrl  = i_wr_stb && (i_addr == `UART_CTRL_ADDR);
    assign wr_data  = i_wr_stb && (i_addr == `UART_DATA_ADDR);
    assign wr_ien   = i_wr_stb && (i_addr == `UART_IEN_ADDR);
    assign wr_emask = i_wr_stb && (i_addr == `UART_EMASK_ADDR);
    assign rd_data  = i_rd_stb && (i_addr == `UART_DATA_ADDR);
    assign rd_evt   = i_rd_stb && (i_addr == `UART_EVT_ADDR);

    // one-byte buffer: a write while busy would corrupt the frame, so it is dropped
    assign tx_accept = wr_data && uart_en_q && !tx_full_q;
    assign tx_done   = (tx_state_q == TX_STOP) && (tx_cnt_q == 16'h0000);

    // ========================================
    // receive deframer
    uart_rx_deframer u_rx (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_enable   (uart_en_q),
        .i_period   (period),
        .i_rxd      (i_rxd),
        .o_byte     (rx_new_byte),
        .o_valid    (rx_new_valid)
    );

    // ========================================
    // control, enable and mask registers
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            uart_en_q         <= `CTRL_EN_RST;
            baud_sel_q        <= `CTRL_BAUD_RST;
            prescale_active_q <= `CTRL_SCALE_RST;
            uart_ien_q        <= `IEN_UART_RST;
            emask_q           <= `EMASK_RST;
        end else begin
            if (wr_ctrl) begin
                uart_en_q         <= i_wr_data[`CTRL_EN_BIT];
                baud_sel_q        <= i_wr_data[`CTRL_BAUD_MSB:`CTRL_BAUD_LSB];
                prescale_active_q <= i_wr_data[`CTRL_SCALE_BIT];
            end
            if (wr_ien) begin
                uart_ien_q <= i_wr_data[`IEN_UART_BIT];
            end
            if (wr_emask) begin
                emask_q <= i_wr_data[2:0];
            end
        end
    end

    // ========================================
    // receive buffer and flag
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            rx_full_q <= 1'b0;
            rx_byte_q <= 8'h00;
        end else begin
            if (rx_new_valid) begin
                // arriving byte wins over a same-cycle read clear
                rx_full_q <= 1'b1;
                rx_byte_q <= rx_new_byte;
            end else if (rd_data || !uart_en_q) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // ========================================
    // transmit flag and shifter
    always @(posedge i_core_clk) begin
        if (i_reset || !uart_en_q) begin
            tx_full_q  <= 1'b0;
            tx_state_q <= TX_IDLE;
            tx_cnt_q   <= 16'h0000;
            tx_bit_q   <= 3'h0;
            tx_shift_q <= 8'h00;
        end else begin
            if (tx_accept) begin
                tx_full_q <= 1'b1;
            end else if (tx_done) begin
                tx_full_q <= 1'b0;
            end
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_accept) begin
                        tx_shift_q <= i_wr_data[`DATA_MSB:0];
                        tx_state_q <= TX_START;
                        tx_cnt_q   <= period - 16'h0001;
                    end
                end
                TX_START: begin
                    if (tx_cnt_q == 16'h0000) begin
                        tx_state_q <= TX_DATA;
                        tx_cnt_q   <= period - 16'h0001;
                        tx_bit_q   <= 3'h0;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                TX_DATA: begin
                    if (tx_cnt_q == 16'h0000) begin
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_cnt_q   <= period - 16'h0001;
                        if (tx_bit_q == 3'h7) begin
                            tx_state_q <= TX_STOP;
                        end
                        tx_bit_q <= tx_bit_q + 3'h1;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                TX_STOP: begin
                    if (tx_cnt_q == 16'h0000) begin
                        tx_state_q <= TX_IDLE;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // sticky event bits, cleared by reading
    always @* begin
        evt_d = evt_q;
        if (rd_evt) begin
            evt_d = `EVT_RST;
        end
        // set after clear so a same-cycle event survives
        if (tx_done) begin
            evt_d[`EVT_TXDONE_BIT] = 1'b1;
        end
        if (rx_new_valid) begin
            evt_d[`EVT_RXDONE_BIT] = 1'b1;
            if (rx_full_q && !rd_data) begin
                evt_d[`EVT_OVERRUN_BIT] = 1'b1;
            end
        end
    end

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            evt_q <= `EVT_RST;
        end else begin
            evt_q <= evt_d;
        end
    end

    // ========================================
    // read mux, unmapped addresses read zero
    always @* begin
        rd_data_d = 16'h0000;
        case (i_addr)
            `UART_CTRL_ADDR: begin
                rd_data_d[`CTRL_EN_BIT]                  = uart_en_q;
                rd_data_d[`CTRL_BAUD_MSB:`CTRL_BAUD_LSB] = baud_sel_q;
                rd_data_d[`CTRL_SCALE_BIT]               = prescale_active_q;
            end
            `UART_STAT_ADDR: begin
                rd_data_d[`STAT_TXF_BIT] = tx_full_q;
                rd_data_d[`STAT_RXF_BIT] = rx_full_q;
            end
            `UART_DATA_ADDR: begin
                rd_data_d[`DATA_MSB:0] = rx_byte_q;
            end
            `UART_IEN_ADDR: begin
                rd_data_d[`IEN_UART_BIT] = uart_ien_q;
            end
            `UART_EVT_ADDR: begin
                rd_data_d[2:0] = evt_q;
            end
            `UART_EMASK_ADDR: begin
                rd_data_d[2:0] = emask_q;
            end
            default: begin
                rd_data_d = 16'h0000;
            end
        endcase
    end

    // ========================================
    // registered outputs
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rd_data      <= 16'h0000;
            o_txd          <= 1'b1;
            o_txd_oe       <= 1'b0;
            o_int_rx_full  <= 1'b0;
            o_int_tx_empty <= 1'b0;
            o_irq          <= 1'b0;
        end else begin
            // data valid only in the cycle after the strobe
            o_rd_data <= i_rd_stb ? rd_data_d : 16'h0000;
            // a released pin must not be left low mid-frame
            if (!uart_en_q) begin
                o_txd <= 1'b1;
            end else begin
                case (tx_state_q)
                    TX_START: o_txd <= 1'b0;
                    TX_DATA:  o_txd <= tx_shift_q[0];
                    default:  o_txd <= 1'b1;
                endcase
            end
            o_txd_oe       <= uart_en_q;
            o_int_rx_full  <= uart_ien_q && rx_full_q;
            o_int_tx_empty <= uart_ien_q && !tx_full_q;
            o_irq          <= |(evt_q & emask_q);
        end
    end

endmodule // uart_status_and_data_path

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "uart_status_map.vh"
module tb_top;
    // bit period of 10 cycles at code 0 keeps frames short
    localparam integer CLK_HZ = 1152000;
    logic        i_core_clk = 1'b0;
    logic        i_reset    = 1'b1;
    logic [15:0] i_addr     = 16'h0000;
    logic [15:0] i_wr_data  = 16'h0000;
    logic        i_wr_stb   = 1'b0;
    logic        i_rd_stb   = 1'b0;
    wire  [15:0] o_rd_data;
    wire         rxd, o_txd, o_txd_oe, o_int_rx_full, o_int_tx_empty, o_irq;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [15:0] d;
    int          rates[8] = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};

    always #12.5 i_core_clk = ~i_core_clk;

    uart_status_and_data_path #(.CLK_HZ(CLK_HZ)) i_dut (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
        .o_rd_data(o_rd_data), .i_rxd(rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe),
        .o_int_rx_full(o_int_rx_full), .o_int_tx_empty(o_int_tx_empty), .o_irq(o_irq));
    uart_far_end i_peer (.i_core_clk(i_core_clk), .i_txd(o_txd), .i_txd_oe(o_txd_oe), .o_rxd(rxd));

    // ========================================
    // tasks
    task automatic give_verdict;
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge i_core_clk);
        i_wr_stb <= 1'b1;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_core_clk);
        i_wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge i_core_clk);
        i_rd_stb <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd_stb <= 1'b0;
        #1 v = o_rd_data;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk16(v, exp);
    endtask
    task automatic wait_tx_idle;
        int k;
        for (k = 0; k < 1000; k++) begin
            rd(`UART_STAT_ADDR, d);
            if (d[0] === 1'b0) break;
        end
        if (k == 1000) begin
            n_fail++;
            $display("[FAIL] %0t transmit flag never cleared", $time);
        end
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            give_verdict;
        end
    end

    // ========================================
    // sequence
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_reset <= 1'b0;
        rchk(`UART_STAT_ADDR, 16'h0000);
        rchk(`UART_CTRL_ADDR, 16'h0007);
        chk1(o_txd_oe, 1'b1);
        wr(`UART_STAT_ADDR, 16'h0003);
        rchk(`UART_STAT_ADDR, 16'h0000);
        rchk(16'hc0fe, 16'h0000);
        wr(`UART_CTRL_ADDR, 16'h0001);
        wr(`UART_IEN_ADDR, 16'h0010);
        cyc_wait(2);
        chk1(o_int_tx_empty, 1'b1);
        chk1(o_int_rx_full, 1'b0);
        wr(`UART_DATA_ADDR, 16'h00a5);
        rchk(`UART_STAT_ADDR, 16'h0001);
        chk1(o_int_tx_empty, 1'b0);
        // second write while busy must be dropped
        wr(`UART_DATA_ADDR, 16'h003c);
        wait_tx_idle;
        cyc_wait(120);
        chk16({8'h00, i_peer.got}, 16'h00a5);
        chk16(16'(i_peer.n_got), 16'h0001);
        i_peer.send_byte(8'h5a);
        cyc_wait(3);
        chk1(o_int_rx_full, 1'b1);
        rchk(`UART_STAT_ADDR, 16'h0002);
        rchk(`UART_DATA_ADDR, 16'h005a);
        cyc_wait(2);
        chk1(o_int_rx_full, 1'b0);
        rchk(`UART_STAT_ADDR, 16'h0000);
        rchk(`UART_EVT_ADDR, 16'h0003);
        rchk(`UART_EVT_ADDR, 16'h0000);
        wr(`UART_EMASK_ADDR, 16'h0006);
        i_peer.send_byte(8'h11);
        cyc_wait(3);
        chk1(o_irq, 1'b1);
        i_peer.send_byte(8'h22);
        rchk(`UART_EVT_ADDR, 16'h0006);
        cyc_wait(2);
        chk1(o_irq, 1'b0);
        rchk(`UART_DATA_ADDR, 16'h0022);
        wr(`UART_EMASK_ADDR, 16'h0001);
        i_peer.send_byte(8'h33);
        cyc_wait(3);
        chk1(o_irq, 1'b0);
        wr(`UART_IEN_ADDR, 16'h0000);
        cyc_wait(2);
        chk1(o_int_tx_empty, 1'b0);
        chk1(o_int_rx_full, 1'b0);
        wr(`UART_CTRL_ADDR, 16'h0000);
        wr(`UART_DATA_ADDR, 16'h0055);
        rchk(`UART_STAT_ADDR, 16'h0000);
        chk1(o_txd_oe, 1'b0);
        // every baud code, then code 0 with the prescaler
        for (int k = 0; k < 9; k++) begin
            i_peer.per = (CLK_HZ / rates[k % 8]) * ((k < 8) ? 1 : `PRESCALE_DIV);
            wr(`UART_CTRL_ADDR, 16'(((k % 8) << 1) | ((k / 8) << 4) | 1));
            wr(`UART_DATA_ADDR, 16'h0055);
            wait_tx_idle;
            chk16(16'(i_peer.low_len), 16'(i_peer.per));
            chk16({8'h00, i_peer.got}, 16'h0055);
            chk16(16'(i_peer.n_got), 16'(k + 2));
        end
        give_verdict;
    end
endmodule  // tb_top

bind uart_status_and_data_path uart_path_checker #(.CLK_HZ(CLK_HZ)) i_chk (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_txd(o_txd),
    .o_txd_oe(o_txd_oe), .o_int_rx_full(o_int_rx_full), .o_int_tx_empty(o_int_tx_empty));

/* testbench/uart_far_end.sv */
`timescale 1ns/100ps
// ========================================
// far serial device, one byte at a time
module uart_far_end (
    input  wire logic i_core_clk,  // sampling clock
    input  wire logic i_txd,       // line from block
    input  wire logic i_txd_oe,    // block drives line
    output logic      o_rxd        // line into block
);
    int         per = 10;
    int         low_len = 0;
    int         run = 0;
    int         n_got = 0;
    logic [7:0] got = 8'h00;
    logic [7:0] sh;
    // released pin sits on its pull-up
    wire        line = i_txd_oe ? i_txd : 1'b1;

    initial o_rxd = 1'b1;
    // length of each low run, used to measure the bit period
    always @(posedge i_core_clk) begin
        if (!line) begin
            run <= run + 1;
        end else begin
            if (run != 0) low_len <= run;
            run <= 0;
        end
    end
    initial forever begin
        @(negedge line);
        repeat (per / 2) @(posedge i_core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (per) @(posedge i_core_clk);
            sh[i] = line;
        end
        repeat (per) @(posedge i_core_clk);
        got = sh;
        n_got++;
    end
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_core_clk);
            o_rxd <= fr[i];
            repeat (per - 1) @(posedge i_core_clk);
        end
    endtask
endmodule  // uart_far_end

/* testbench/uart_path_assertions.sv */
`timescale 1ns/100ps
`include "uart_status_map.vh"
// ========================================
// port checks for the status and data path
module uart_path_checker #(
    parameter integer CLK_HZ = 40000000
) (
    input wire logic        i_core_clk,     // core clock
    input wire logic        i_reset,        // sync reset
    input wire logic [15:0] i_addr,         // address
    input wire logic [15:0] i_wr_data,      // write data
    input wire logic        i_wr_stb,       // write strobe
    input wire logic        i_rd_stb,       // read strobe
    input wire logic [15:0] o_rd_data,      // read data
    input wire logic        o_txd,          // serial out
    input wire logic        o_txd_oe,       // pin enable
    input wire logic        o_int_rx_full,  // rx interrupt
    input wire logic        o_int_tx_empty  // tx interrupt
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    // only a write that the block can accept: enabled and tx empty
    sequence seq_tx_take;
        i_wr_stb && i_addr == `UART_DATA_ADDR && o_int_tx_empty && o_txd_oe;
    endsequence
    sequence seq_data_rd;
        i_rd_stb && i_addr == `UART_DATA_ADDR;
    endsequence

    chk_rd_idle_zero: assert property (!$past(i_rd_stb) |-> o_rd_data == 16'h0000)
        else $error("read data not zero outside read cycle");
    chk_stat_upper: assert property (i_rd_stb && i_addr == `UART_STAT_ADDR |=> o_rd_data[15:2] == 14'h0000)
        else $error("status reserved bits not zero");
    chk_data_upper: assert property (seq_data_rd |=> o_rd_data[15:8] == 8'h00)
        else $error("data upper byte not zero");
    chk_tx_start: assert property (seq_tx_take |-> ##2 (!o_txd) [*8])
        else $error("start bit missing after data write");
    chk_tx_busy_flag: assert property (seq_tx_take |-> ##2 (!o_int_tx_empty) [*8] ##[1:1000] o_int_tx_empty)
        else $error("transmit full not set then cleared");
    chk_rx_clear: assert property (seq_data_rd |-> ##2 !o_int_rx_full)
        else $error("receive full not cleared by data read");
    chk_oe_follow: assert property (i_wr_stb && i_addr == `UART_CTRL_ADDR |-> ##2
        o_txd_oe == $past(i_wr_data[`CTRL_EN_BIT], 2))
        else $error("pin enable does not follow enable bit");
    chk_idle_high: assert property (!o_txd_oe |-> o_txd)
        else $error("transmit line not idle high when released");
endmodule  // uart_path_checker
